// ---- common/sbr_pkg.sv ----
// shared constants for the stack, i/o bit and rotate execution unit
// assumes one core clock; every width and code lives here
package sbr_pkg;

  // operand widths
  localparam int DATA_W = 8;
  localparam int REG_AW = 5;
  localparam int IO_AW = 6;
  localparam int BIT_AW = 3;
  localparam int SP_W = 8;
  localparam int FLAG_W = 4;

  // stack pointer reset value and step per byte
  localparam logic [SP_W-1:0] SP_RESET = 8'hFF;
  localparam logic [SP_W-1:0] SP_STEP = 8'h01;

  // status flag positions inside the flag vector
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;

  // operations this unit executes
  typedef enum logic [2:0] {
    OP_STACK_STORE = 3'h0,
    OP_STACK_LOAD = 3'h1,
    OP_IO_BIT_SET = 3'h2,
    OP_IO_BIT_CLEAR = 3'h3,
    OP_ROTATE_LEFT_CARRY = 3'h4,
    OP_ROTATE_RIGHT_CARRY = 3'h5,
    OP_LOGICAL_RIGHT_SHIFT = 3'h6,
    OP_NONE = 3'h7
  } sbr_op_e;

  // execution phases: two-cycle operations pass through the second one
  typedef enum logic [0:0] {
    ST_IDLE = 1'h0,
    ST_SECOND = 1'h1
  } sbr_state_e;

  // zero and single-bit constants sized for the operand paths
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;

endpackage

// ---- src/sbr_stack_mem.sv ----
// byte-wide stack storage with one write port and a registered read port
// assumes write and read addresses come from the same clock domain
`timescale 1ns/100ps
`default_nettype none

module sbr_stack_mem (
  // clock
  input wire logic clk_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [sbr_pkg::SP_W-1:0] wr_addr_i,
  input wire logic [sbr_pkg::DATA_W-1:0] wr_data_i,
  // read port
  input wire logic rd_en_i,
  input wire logic [sbr_pkg::SP_W-1:0] rd_addr_i,
  output logic [sbr_pkg::DATA_W-1:0] rd_data_o
);

  logic [sbr_pkg::DATA_W-1:0] mem [0:(1 << sbr_pkg::SP_W)-1];

  // write store
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // registered read data
  always_ff @(posedge clk_i) begin
    if (rd_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

`default_nettype wire

// ---- src/sbr_exec.sv ----
// execution unit for stack store/load, i/o bit set/clear and carry rotates
// assumes register file and i/o read data arrive combinationally on the start cycle
// How it works
// - store writes register to stack, two cycles
// - load takes stack top into register, two
// - bit set forces one i/o bit high
// - bit clear forces one i/o bit low
// - left rotate through carry, flags, one cycle
// - right rotate through carry, flags, one cycle
`timescale 1ns/100ps
`default_nettype none

module sbr_exec (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // operation request
  input wire logic start_i,
  input wire logic [2:0] op_i,
  input wire logic [sbr_pkg::REG_AW-1:0] reg_sel_i,
  input wire logic [sbr_pkg::IO_AW-1:0] io_addr_i,
  input wire logic [sbr_pkg::BIT_AW-1:0] bit_sel_i,
  // operand sources
  input wire logic [sbr_pkg::DATA_W-1:0] rf_rdata_i,
  input wire logic [sbr_pkg::DATA_W-1:0] io_rdata_i,
  input wire logic [sbr_pkg::FLAG_W-1:0] flags_i,
  // progress
  output logic busy_o,
  output logic done_o,
  // register file write
  output logic rf_we_o,
  output logic [sbr_pkg::REG_AW-1:0] rf_waddr_o,
  output logic [sbr_pkg::DATA_W-1:0] rf_wdata_o,
  // status flag write
  output logic flag_we_o,
  output logic [sbr_pkg::FLAG_W-1:0] flags_o,
  // i/o register write
  output logic io_we_o,
  output logic [sbr_pkg::IO_AW-1:0] io_addr_o,
  output logic [sbr_pkg::DATA_W-1:0] io_wdata_o,
  // stack pointer view
  output logic [sbr_pkg::SP_W-1:0] sp_o
);

  // reset release synchroniser
  logic rst_meta_n;
  logic rst_n;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  sbr_pkg::sbr_state_e state;
  sbr_pkg::sbr_state_e next_state;
  sbr_pkg::sbr_op_e op_q;
  logic [sbr_pkg::REG_AW-1:0] reg_q;
  logic [sbr_pkg::IO_AW-1:0] io_addr_q;
  logic [sbr_pkg::DATA_W-1:0] io_val_q;
  logic [sbr_pkg::DATA_W-1:0] stack_rdata;

  // request decode
  wire take = start_i && (state == sbr_pkg::ST_IDLE);
  wire is_store = take && (op_i == 3'(sbr_pkg::OP_STACK_STORE));
  wire is_load = take && (op_i == 3'(sbr_pkg::OP_STACK_LOAD));
  wire is_set = take && (op_i == 3'(sbr_pkg::OP_IO_BIT_SET));
  wire is_clr = take && (op_i == 3'(sbr_pkg::OP_IO_BIT_CLEAR));
  wire is_rol = take && (op_i == 3'(sbr_pkg::OP_ROTATE_LEFT_CARRY));
  wire is_ror = take && (op_i == 3'(sbr_pkg::OP_ROTATE_RIGHT_CARRY));
  wire is_lsr = take && (op_i == 3'(sbr_pkg::OP_LOGICAL_RIGHT_SHIFT));
  wire is_two = is_store || is_load || is_set || is_clr;
  wire is_one = is_rol || is_ror || is_lsr;
  wire carry_in = flags_i[sbr_pkg::FLAG_C];

  // i/o read-modify-write values
  wire [sbr_pkg::DATA_W-1:0] bit_mask = sbr_pkg::BIT_ONE << bit_sel_i;
  wire [sbr_pkg::DATA_W-1:0] set_val = io_rdata_i | bit_mask;
  wire [sbr_pkg::DATA_W-1:0] clr_val = io_rdata_i & ~bit_mask;

  // shift and rotate results
  wire [sbr_pkg::DATA_W-1:0] rol_val = {rf_rdata_i[sbr_pkg::DATA_W-2:0], carry_in};
  wire [sbr_pkg::DATA_W-1:0] ror_val = {carry_in, rf_rdata_i[sbr_pkg::DATA_W-1:1]};
  wire [sbr_pkg::DATA_W-1:0] lsr_val = {1'b0, rf_rdata_i[sbr_pkg::DATA_W-1:1]};
  wire [sbr_pkg::DATA_W-1:0] sh_val = is_rol ? rol_val : (is_ror ? ror_val : lsr_val);
  wire sh_c = is_rol ? rf_rdata_i[sbr_pkg::DATA_W-1] : rf_rdata_i[0];
  wire sh_n = sh_val[sbr_pkg::DATA_W-1];
  wire sh_z = (sh_val == sbr_pkg::DATA_ZERO);
  wire [sbr_pkg::FLAG_W-1:0] sh_flags = {sh_n ^ sh_c, sh_n, sh_z, sh_c};

  // stack addressing: store writes at sp, load reads at sp plus one
  wire [sbr_pkg::SP_W-1:0] sp_up = sp_o + sbr_pkg::SP_STEP;
  wire [sbr_pkg::SP_W-1:0] sp_down = sp_o - sbr_pkg::SP_STEP;
  wire [sbr_pkg::SP_W-1:0] next_sp = is_store ? sp_down : (is_load ? sp_up : sp_o);

  // finishing decode of the second cycle
  wire fin = (state == sbr_pkg::ST_SECOND);
  wire fin_load = fin && (op_q == sbr_pkg::OP_STACK_LOAD);
  wire fin_io = fin && ((op_q == sbr_pkg::OP_IO_BIT_SET) || (op_q == sbr_pkg::OP_IO_BIT_CLEAR));

  // phase selection
  always_comb begin
    case (state)
      sbr_pkg::ST_IDLE: begin
        next_state = is_two ? sbr_pkg::ST_SECOND : sbr_pkg::ST_IDLE;
      end
      sbr_pkg::ST_SECOND: begin
        next_state = sbr_pkg::ST_IDLE;
      end
      default: begin
        next_state = sbr_pkg::ST_IDLE;
      end
    endcase
  end

  sbr_stack_mem u_stack (
    .clk_i(sys_clk_i),
    .wr_en_i(is_store),
    .wr_addr_i(sp_o),
    .wr_data_i(rf_rdata_i),
    .rd_en_i(is_load),
    .rd_addr_i(sp_up),
    .rd_data_o(stack_rdata)
  );

  // phase, latched operands and stack pointer
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= sbr_pkg::ST_IDLE;
      op_q <= sbr_pkg::OP_NONE;
      reg_q <= '0;
      io_addr_q <= '0;
      io_val_q <= sbr_pkg::DATA_ZERO;
      sp_o <= sbr_pkg::SP_RESET;
    end else begin
      state <= next_state;
      sp_o <= next_sp;
      if (take) begin
        op_q <= sbr_pkg::sbr_op_e'(op_i);
        reg_q <= reg_sel_i;
        io_addr_q <= io_addr_i;
        io_val_q <= is_set ? set_val : clr_val;
      end
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      rf_we_o <= 1'b0;
      rf_waddr_o <= '0;
      rf_wdata_o <= sbr_pkg::DATA_ZERO;
      flag_we_o <= 1'b0;
      flags_o <= '0;
      io_we_o <= 1'b0;
      io_addr_o <= '0;
      io_wdata_o <= sbr_pkg::DATA_ZERO;
    end else begin
      busy_o <= is_two;
      done_o <= is_one || fin;
      rf_we_o <= is_one || fin_load;
      rf_waddr_o <= fin ? reg_q : reg_sel_i;
      rf_wdata_o <= fin_load ? stack_rdata : sh_val;
      flag_we_o <= is_one;
      flags_o <= sh_flags;
      io_we_o <= fin_io;
      io_addr_o <= io_addr_q;
      io_wdata_o <= io_val_q;
    end
  end

  // checks
  property p_store;
    @(posedge sys_clk_i) disable iff (!rst_n)
    is_store |=> busy_o && !done_o ##1 done_o && !flag_we_o && !rf_we_o &&
      sp_o == $past(sp_o, 2) - sbr_pkg::SP_STEP;
  endproperty
  a_store: assert property (p_store) else $error("stack store timing or pointer wrong");

  property p_load;
    @(posedge sys_clk_i) disable iff (!rst_n)
    is_load |=> !done_o ##1 done_o && rf_we_o && !flag_we_o && rf_waddr_o == $past(reg_sel_i, 2);
  endproperty
  a_load: assert property (p_load) else $error("stack load did not write register in two cycles");

  property p_set;
    @(posedge sys_clk_i) disable iff (!rst_n)
    is_set |-> ##2 io_we_o && done_o && !flag_we_o &&
      io_wdata_o == ($past(io_rdata_i, 2) | (sbr_pkg::BIT_ONE << $past(bit_sel_i, 2)));
  endproperty
  a_set: assert property (p_set) else $error("bit set wrote wrong value or time");

  property p_clr;
    @(posedge sys_clk_i) disable iff (!rst_n)
    is_clr |-> ##2 io_we_o && io_addr_o == $past(io_addr_i, 2) &&
      io_wdata_o == ($past(io_rdata_i, 2) & ~(sbr_pkg::BIT_ONE << $past(bit_sel_i, 2)));
  endproperty
  a_clr: assert property (p_clr) else $error("bit clear wrote wrong value or address");

  property p_rol;
    @(posedge sys_clk_i) disable iff (!rst_n)
    is_rol |=> done_o && flag_we_o && rf_wdata_o[0] == $past(carry_in) &&
      flags_o[sbr_pkg::FLAG_C] == $past(rf_rdata_i[sbr_pkg::DATA_W-1]);
  endproperty
  a_rol: assert property (p_rol) else $error("left rotate result or carry wrong");

  property p_ror;
    @(posedge sys_clk_i) disable iff (!rst_n)
    is_ror |=> rf_we_o && rf_wdata_o[sbr_pkg::DATA_W-1] == $past(carry_in) &&
      flags_o[sbr_pkg::FLAG_C] == $past(rf_rdata_i[0]);
  endproperty
  a_ror: assert property (p_ror) else $error("right rotate result or carry wrong");

  property p_lsr;
    @(posedge sys_clk_i) disable iff (!rst_n)
    is_lsr |=> rf_we_o && !rf_wdata_o[sbr_pkg::DATA_W-1] && !flags_o[sbr_pkg::FLAG_N] &&
      flags_o[sbr_pkg::FLAG_V] == flags_o[sbr_pkg::FLAG_C];
  endproperty
  a_lsr: assert property (p_lsr) else $error("logical shift did not zero fill");

  property p_sp;
    @(posedge sys_clk_i) disable iff (!rst_n)
    $changed(sp_o) |-> ($past(is_store) && sp_o == $past(sp_o) - sbr_pkg::SP_STEP) ||
      ($past(is_load) && sp_o == $past(sp_o) + sbr_pkg::SP_STEP);
  endproperty
  a_sp: assert property (p_sp) else $error("stack pointer moved without a stack operation");

endmodule

`default_nettype wire

// ---- test/sbr_exec_test.sv ----
// self-checking bench for the stack, i/o bit and rotate execution unit
// assumes sbr_pkg is compiled first; inputs driven at the falling edge
`timescale 1ns/100ps
`default_nettype none

module sbr_exec_test;
  // one-cycle shift row: op, operand, carry in, result, flags {V,N,Z,C}
  typedef struct packed {logic [2:0] op; logic [7:0] d; logic c; logic [7:0] res; logic [3:0] f;} sbr_row_s;
  localparam sbr_row_s ROWS [7] = '{
    '{3'h4, 8'h80, 1'b0, 8'h00, 4'hB},
    '{3'h4, 8'h40, 1'b1, 8'h81, 4'hC},
    '{3'h4, 8'hFF, 1'b1, 8'hFF, 4'h5},
    '{3'h5, 8'h01, 1'b0, 8'h00, 4'hB},
    '{3'h5, 8'h02, 1'b1, 8'h81, 4'hC},
    '{3'h6, 8'h01, 1'b1, 8'h00, 4'hB},
    '{3'h6, 8'hFE, 1'b1, 8'h7F, 4'h0}};
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  logic [2:0] op = 3'h7;
  logic [4:0] reg_sel = 5'h00;
  logic [5:0] io_addr = 6'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [7:0] rf_rdata = 8'h00;
  logic [7:0] io_rdata = 8'h00;
  logic [3:0] flags_in = 4'h0;
  logic busy, done, rf_we, flag_we, io_we;
  logic [4:0] rf_waddr;
  logic [7:0] rf_wdata, io_wdata, sp;
  logic [3:0] flags_out;
  logic [5:0] io_addr_out;
  int error_cnt = 0;
  int cmp_count = 0;

  // core clock, 8 ns period
  always #4 sys_clk = ~sys_clk;

  sbr_exec dut (
    .sys_clk_i(sys_clk), .rstn_i(rstn), .start_i(start), .op_i(op), .reg_sel_i(reg_sel),
    .io_addr_i(io_addr), .bit_sel_i(bit_sel), .rf_rdata_i(rf_rdata), .io_rdata_i(io_rdata),
    .flags_i(flags_in), .busy_o(busy), .done_o(done), .rf_we_o(rf_we), .rf_waddr_o(rf_waddr),
    .rf_wdata_o(rf_wdata), .flag_we_o(flag_we), .flags_o(flags_out), .io_we_o(io_we),
    .io_addr_o(io_addr_out), .io_wdata_o(io_wdata), .sp_o(sp)
  );

  // compare and count
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // two-cycle op: busy after first edge, done after second, flags never written
  task automatic run2(input logic [2:0] o, input logic [7:0] d, input logic [7:0] iv, input logic [2:0] b);
    op = o;
    rf_rdata = d;
    io_rdata = iv;
    bit_sel = b;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    rf_rdata = ~d;
    io_rdata = ~iv;
    chk("busy_done", {6'h00, busy, done}, 8'h02);
    @(negedge sys_clk);
    chk("done_flagwe", {6'h00, done, flag_we}, 8'h02);
  endtask

  // watchdog
  initial begin
    #(8 * 500);
    error_cnt++;
    $display("[FAIL] watchdog expired");
    test_done();
  end

  initial begin
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("sp_reset", sp, 8'hFF);
    chk("pulses_reset", {3'h0, busy, done, rf_we, flag_we, io_we}, 8'h00);
    $display("reset test done");
    // shift and rotate rows, issued back to back
    reg_sel = 5'h0A;
    for (int i = 0; i < 7; i++) begin
      op = ROWS[i].op;
      rf_rdata = ROWS[i].d;
      flags_in = {3'h5, ROWS[i].c};
      start = 1'b1;
      @(negedge sys_clk);
      chk("result", rf_wdata, ROWS[i].res);
      chk("flags", {4'h0, flags_out}, {4'h0, ROWS[i].f});
      chk("pulses", {3'h0, busy, done, rf_we, flag_we, io_we}, 8'h0E);
      chk("waddr", {3'h0, rf_waddr}, 8'h0A);
    end
    start = 1'b0;
    @(negedge sys_clk);
    chk("pulses_idle", {3'h0, busy, done, rf_we, flag_we, io_we}, 8'h00);
    $display("shift test done");
    // stack: two stores then two loads come back in reverse order
    reg_sel = 5'h03;
    run2(sbr_pkg::OP_STACK_STORE, 8'hA5, 8'h00, 3'h0);
    chk("sp_st1", sp, 8'hFE);
    chk("rfwe_st", {7'h00, rf_we}, 8'h00);
    run2(sbr_pkg::OP_STACK_STORE, 8'h3C, 8'h00, 3'h0);
    chk("sp_st2", sp, 8'hFD);
    reg_sel = 5'h11;
    run2(sbr_pkg::OP_STACK_LOAD, 8'h00, 8'h00, 3'h0);
    chk("ld1", rf_wdata, 8'h3C);
    chk("ld1_we_addr", {2'h0, rf_we, rf_waddr}, 8'h31);
    chk("sp_ld1", sp, 8'hFE);
    run2(sbr_pkg::OP_STACK_LOAD, 8'h00, 8'h00, 3'h0);
    chk("ld2", rf_wdata, 8'hA5);
    chk("sp_ld2", sp, 8'hFF);
    $display("stack test done");
    // i/o bit set at bits 2 and 0, clear at bit 7
    io_addr = 6'h2A;
    run2(sbr_pkg::OP_IO_BIT_SET, 8'h00, 8'h10, 3'h2);
    chk("set", io_wdata, 8'h14);
    chk("set_we_addr", {1'b0, io_we, io_addr_out}, 8'h6A);
    run2(sbr_pkg::OP_IO_BIT_SET, 8'h00, 8'hFE, 3'h0);
    chk("set0", io_wdata, 8'hFF);
    run2(sbr_pkg::OP_IO_BIT_CLEAR, 8'h00, 8'hFF, 3'h7);
    chk("clr7", io_wdata, 8'h7F);
    chk("clr_we", {7'h00, io_we}, 8'h01);
    $display("io bit test done");
    // start in the second cycle is refused; op none is taken and does nothing
    op = 3'h0;
    rf_rdata = 8'h66;
    start = 1'b1;
    @(negedge sys_clk);
    op = 3'h6;
    @(negedge sys_clk);
    chk("refused", {3'h0, busy, done, rf_we, flag_we, io_we}, 8'h08);
    op = 3'h7;
    @(negedge sys_clk);
    chk("op_none", {3'h0, busy, done, rf_we, flag_we, io_we}, 8'h00);
    chk("sp_refused", sp, 8'hFE);
    start = 1'b0;
    @(negedge sys_clk);
    $display("refusal test done");
    // reset in mid-run returns the stack pointer to its start
    run2(sbr_pkg::OP_STACK_STORE, 8'h55, 8'h00, 3'h0);
    rstn = 1'b0;
    @(negedge sys_clk);
    chk("sp_midreset", sp, 8'hFF);
    rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("io_midreset", io_wdata, 8'h00);
    chk("ioaddr_midreset", {1'b0, io_we, io_addr_out}, 8'h00);
    // first request after release works again from the reset pointer
    run2(sbr_pkg::OP_STACK_STORE, 8'h77, 8'h00, 3'h0);
    chk("sp_after_reset", sp, 8'hFE);
    run2(sbr_pkg::OP_STACK_LOAD, 8'h00, 8'h00, 3'h0);
    chk("ld_after_reset", rf_wdata, 8'h77);
    chk("sp_ld_after_reset", sp, 8'hFF);
    $display("mid-run reset test done");
    test_done();
  end
endmodule

`default_nettype wire
